// file: rcr_host_model.sv
// host side of the control pins: drives both regulator requests and both core resets
// assumes the bench hands it the wanted pin levels; it drives them at a rising edge
`timescale 1ns/1ps
module rcr_host_model (
  input wire logic clock,
  input wire logic [3:0] want,
  output logic wlan_regulator_request,
  output logic bluetooth_regulator_request,
  output logic wlan_core_reset_n,
  output logic bluetooth_core_reset_n
);
  // pins start at a defined low level, so the device never sees a floating reset
  initial begin
    wlan_regulator_request = 1'b0;
    bluetooth_regulator_request = 1'b0;
    wlan_core_reset_n = 1'b0;
    bluetooth_core_reset_n = 1'b0;
  end

  // a level is only changed when the bench asks, so every step lasts as long as it likes
  always @(posedge clock) begin
    wlan_regulator_request <= want[0];
    bluetooth_regulator_request <= want[1];
    wlan_core_reset_n <= want[2];
    bluetooth_core_reset_n <= want[3];
  end
endmodule : rcr_host_model

// file: rcr_pkg.sv
// regulator and core reset control: shared constants for the sequencer
// assumes a 250 MHz clock and an APB master with 32-bit data
// Behaviour
// - regulators run when either request is high
// - power-up reset lasts at most 110 ms
// - external resets ORed with power-up reset
// - low wlan reset shuts wlan core down
// - low bluetooth reset holds bluetooth core
// - fm follows bluetooth reset and enable
package rcr_pkg;

  // power-up reset span
  localparam int unsigned POR_TIME_MS = 110;
  localparam int unsigned CLK_FREQ_KHZ = 250000;
  // longest time: product is exact, so no rounding is lost
  localparam int unsigned POR_CYCLES_DEF = POR_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned POR_CNT_W = 25;

  // apb map
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_POR_COUNT = 12'h008;

  // control register fields
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned CTRL_WLAN_HOLD = 0;
  localparam int unsigned CTRL_BT_HOLD = 1;
  localparam int unsigned CTRL_FM_HOLD = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // status register fields
  localparam int unsigned ST_W = 11;
  localparam int unsigned ST_REG_EN = 0;
  localparam int unsigned ST_POR = 1;
  localparam int unsigned ST_WLAN_HOLD = 2;
  localparam int unsigned ST_BT_HOLD = 3;
  localparam int unsigned ST_FM_HOLD = 4;
  localparam int unsigned ST_WREQ = 5;
  localparam int unsigned ST_BREQ = 6;
  localparam int unsigned ST_WRST = 7;
  localparam int unsigned ST_BRST = 8;
  localparam int unsigned ST_CORE_SUP = 9;
  localparam int unsigned ST_IO_SUP = 10;

  // synchroniser lanes
  localparam int unsigned SYN_W = 6;
  localparam int unsigned SYN_WREQ = 0;
  localparam int unsigned SYN_BREQ = 1;
  localparam int unsigned SYN_WRST = 2;
  localparam int unsigned SYN_BRST = 3;
  localparam int unsigned SYN_CORE_SUP = 4;
  localparam int unsigned SYN_IO_SUP = 5;

endpackage : rcr_pkg

// file: rcr_sync.sv
// regulator and core reset control: two-flop synchroniser bank
// assumes inputs are asynchronous pins; outputs read low during reset
`timescale 1ns/1ps
module rcr_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule : rcr_sync

// file: rcr_top.sv
// regulator and core reset control: power-up reset, regulator enable,
// per-core reset holds and a small apb register block
// assumes all control pins and supply-good levels are asynchronous to clock
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module rcr_top
  import rcr_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  // supply comparators, high once above threshold
  input wire logic core_supply_good,
  input wire logic io_supply_good,
  // host control pins
  input wire logic wlan_regulator_request,
  input wire logic bluetooth_regulator_request,
  input wire logic wlan_core_reset_n,
  input wire logic bluetooth_core_reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // power and reset results
  output logic regulator_enable,
  output logic por_active,
  output logic wlan_core_hold,
  output logic bluetooth_core_hold,
  output logic fm_core_hold
);

  // elaboration check on the power-up span
  if (POR_CYCLES < 1 || POR_CYCLES >= (2 ** POR_CNT_W)) begin : g_por_check
    $error("POR_CYCLES out of range for counter");
  end

  localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES - 1);
  localparam logic [POR_CNT_W-1:0] POR_ONE = POR_CNT_W'(1);

  logic [SYN_W-1:0] pin_raw;
  logic [SYN_W-1:0] pin_sync;
  logic wreq_s;
  logic breq_s;
  logic wrst_n_s;
  logic brst_n_s;
  logic supplies_ok;

  logic regulator_enable_ff;
  logic por_active_ff;
  logic [POR_CNT_W-1:0] por_cnt_ff;
  logic wlan_hold_ff;
  logic bt_hold_ff;
  logic fm_hold_ff;
  logic nxt_wlan_hold;
  logic nxt_bt_hold;
  logic nxt_fm_hold;

  logic [CTRL_W-1:0] ctrl_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [APB_DW-1:0] prdata_ff;
  logic apb_access;
  logic apb_done;
  logic [APB_DW-1:0] rd_mux;
  logic rd_err;
  logic [ST_W-1:0] status_vec;

  // every pin crosses two flops before any logic looks at it
  assign pin_raw[SYN_WREQ] = wlan_regulator_request;
  assign pin_raw[SYN_BREQ] = bluetooth_regulator_request;
  assign pin_raw[SYN_WRST] = wlan_core_reset_n;
  assign pin_raw[SYN_BRST] = bluetooth_core_reset_n;
  assign pin_raw[SYN_CORE_SUP] = core_supply_good;
  assign pin_raw[SYN_IO_SUP] = io_supply_good;

  rcr_sync #(
    .W(SYN_W)
  ) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(pin_raw),
    .sync_out(pin_sync)
  );

  assign wreq_s = pin_sync[SYN_WREQ];
  assign breq_s = pin_sync[SYN_BREQ];
  assign wrst_n_s = pin_sync[SYN_WRST];
  assign brst_n_s = pin_sync[SYN_BRST];
  // both supplies must be up; either dropping restarts the span
  assign supplies_ok = pin_sync[SYN_CORE_SUP] & pin_sync[SYN_IO_SUP];

  // regulators run on either request, off only when both are low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regulator_enable_ff <= 1'b0;
    end else begin
      regulator_enable_ff <= wreq_s | breq_s;
    end
  end

  // power-up reset: counts a fixed span once both supplies are good;
  // the span is the upper bound, so it ends exactly at the last count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      por_active_ff <= 1'b1;
      por_cnt_ff <= '0;
    end else if (!supplies_ok) begin
      por_active_ff <= 1'b1;
      por_cnt_ff <= '0;
    end else if (por_active_ff) begin
      if (por_cnt_ff == POR_LAST) begin
        por_active_ff <= 1'b0;
      end else begin
        por_cnt_ff <= por_cnt_ff + POR_ONE;
      end
    end
  end

  // hold terms: any single source keeps a core in reset
  always_comb begin
    nxt_wlan_hold = !regulator_enable_ff
      | por_active_ff
      | !wrst_n_s
      | ctrl_ff[CTRL_WLAN_HOLD];
    nxt_bt_hold = !regulator_enable_ff
      | por_active_ff
      | !brst_n_s
      | ctrl_ff[CTRL_BT_HOLD];
    // fm shares the bluetooth core, so it can never outlive its reset
    nxt_fm_hold = nxt_bt_hold | ctrl_ff[CTRL_FM_HOLD];
  end

  // core hold flops; all three come up held
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wlan_hold_ff <= 1'b1;
      bt_hold_ff <= 1'b1;
      fm_hold_ff <= 1'b1;
    end else begin
      wlan_hold_ff <= nxt_wlan_hold;
      bt_hold_ff <= nxt_bt_hold;
      fm_hold_ff <= nxt_fm_hold;
    end
  end

  assign regulator_enable = regulator_enable_ff;
  assign por_active = por_active_ff;
  assign wlan_core_hold = wlan_hold_ff;
  assign bluetooth_core_hold = bt_hold_ff;
  assign fm_core_hold = fm_hold_ff;

  // apb: one wait state, so every access phase lasts two cycles
  assign apb_access = psel & penable;
  assign apb_done = apb_access & pready_ff;

  // status snapshot for software
  always_comb begin
    status_vec = '0;
    status_vec[ST_REG_EN] = regulator_enable_ff;
    status_vec[ST_POR] = por_active_ff;
    status_vec[ST_WLAN_HOLD] = wlan_hold_ff;
    status_vec[ST_BT_HOLD] = bt_hold_ff;
    status_vec[ST_FM_HOLD] = fm_hold_ff;
    status_vec[ST_WREQ] = wreq_s;
    status_vec[ST_BREQ] = breq_s;
    status_vec[ST_WRST] = wrst_n_s;
    status_vec[ST_BRST] = brst_n_s;
    status_vec[ST_CORE_SUP] = pin_sync[SYN_CORE_SUP];
    status_vec[ST_IO_SUP] = pin_sync[SYN_IO_SUP];
  end

  // read decode; writes to read-only or unmapped words are errors
  always_comb begin
    rd_mux = '0;
    rd_err = 1'b0;
    case (paddr)
      ADDR_CTRL: begin
        rd_mux = {{(APB_DW - CTRL_W){1'b0}}, ctrl_ff};
      end
      ADDR_STATUS: begin
        rd_mux = {{(APB_DW - ST_W){1'b0}}, status_vec};
        rd_err = pwrite;
      end
      ADDR_POR_COUNT: begin
        rd_mux = {{(APB_DW - POR_CNT_W){1'b0}}, por_cnt_ff};
        rd_err = pwrite;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // answer is built in the first access cycle and shown in the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else if (apb_access && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= rd_err;
      prdata_ff <= pwrite ? '0 : rd_mux;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
  end

  // control register: software holds on top of the pin resets
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RESET;
    end else if (apb_done && pwrite && paddr == ADDR_CTRL) begin
      ctrl_ff <= pwdata[CTRL_W-1:0];
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ---- checks ----
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  localparam logic [POR_CNT_W:0] POR_LIMIT = (POR_CNT_W + 1)'(POR_CYCLES);
  localparam logic [POR_CNT_W:0] WAIT_ONE = (POR_CNT_W + 1)'(1);
  logic [POR_CNT_W:0] por_wait_ff;

  // independent count of good-supply cycles spent in power-up reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      por_wait_ff <= '0;
    end else if (!supplies_ok || !por_active_ff) begin
      por_wait_ff <= '0;
    end else if (por_wait_ff <= POR_LIMIT) begin
      por_wait_ff <= por_wait_ff + WAIT_ONE;
    end
  end

  sequence wlan_free_s;
    regulator_enable_ff && !por_active_ff && wrst_n_s && !ctrl_ff[CTRL_WLAN_HOLD];
  endsequence

  sequence bt_free_s;
    regulator_enable_ff && !por_active_ff && brst_n_s && !ctrl_ff[CTRL_BT_HOLD];
  endsequence

  // fm is free only when its own soft hold is clear as well
  sequence fm_free_s;
    regulator_enable_ff && !por_active_ff && brst_n_s
      && !ctrl_ff[CTRL_BT_HOLD] && !ctrl_ff[CTRL_FM_HOLD];
  endsequence

  // first access cycle of an apb transfer, before the answer is shown
  sequence apb_wait_s;
    psel && penable && !pready_ff;
  endsequence

  reg_or_a: assert property ((wreq_s || breq_s) |=> regulator_enable)
    else $error("regulator off while a request is high");
  reg_off_a: assert property (!wreq_s && !breq_s |=> !regulator_enable)
    else $error("regulator on with both requests low");
  por_bound_a: assert property (por_wait_ff <= POR_LIMIT)
    else $error("power-up reset exceeded its span");
  por_restart_a: assert property (!supplies_ok |=> por_active ##1 por_active)
    else $error("power-up reset not asserted on supply loss");
  por_or_a: assert property (por_active_ff |=> wlan_core_hold && bluetooth_core_hold)
    else $error("core released during power-up reset");
  wlan_shut_a: assert property (!wrst_n_s && brst_n_s |=> wlan_core_hold)
    else $error("wlan core running with its reset low");
  bt_release_a: assert property (bt_free_s |=> !bluetooth_core_hold)
    else $error("bluetooth core not released");
  bt_hold_a: assert property (!brst_n_s |=> bluetooth_core_hold)
    else $error("bluetooth core running with its reset low");
  fm_follow_a: assert property (bluetooth_core_hold |-> fm_core_hold)
    else $error("fm running while bluetooth core held");
  release_gate_a: assert property (!wlan_core_hold |-> $past(regulator_enable_ff)
    && !$past(por_active_ff) && $past(wrst_n_s))
    else $error("wlan core released without all conditions");
  wlan_release_a: assert property (wlan_free_s |=> !wlan_core_hold)
    else $error("wlan core not released when free");
  // a low wlan reset wins whatever the bluetooth reset does
  wlan_any_a: assert property (!wrst_n_s |=> wlan_core_hold)
    else $error("wlan core running while its reset is low");
  bt_gate_a: assert property (!bluetooth_core_hold |-> $past(regulator_enable_ff)
    && !$past(por_active_ff) && $past(brst_n_s))
    else $error("bluetooth core released without all conditions");
  fm_release_a: assert property (fm_free_s |=> !fm_core_hold)
    else $error("fm not released with the bluetooth core");
  por_end_a: assert property (por_wait_ff == POR_LIMIT |-> !por_active_ff)
    else $error("power-up reset outlived its span");
  // the answer comes after exactly one wait state and stands for one cycle
  rdy_wait_a: assert property (apb_wait_s |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");
  rdy_idle_a: assert property (!pready |-> !pslverr && prdata == '0)
    else $error("apb response shown outside the ready cycle");

endmodule : rcr_top

// file: tb_top.sv
// self-checking bench for the regulator and core reset sequencer
// assumes a short power-up count; results are read back over apb and checked from a queue
`timescale 1ns/1ps
module tb_top;
  import rcr_pkg::*;
  localparam int unsigned PC = 20;
  logic clock, rst_n, cs, ios, psel, penable, pwrite, pready, pslverr;
  logic reg_en, por, wh, bh, fh, wreq, breq, wrst_n, brst_n, por_e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0] pins;
  logic [2:0] ctrl;
  logic [37:0] q_val[$], q_msk[$];
  logic [37:0] ev, em;
  int n_mismatch = 0;
  int checked = 0;
  int seed = 32'h7e47;

  // free-running 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  rcr_host_model host (.clock(clock), .want(pins), .wlan_regulator_request(wreq),
    .bluetooth_regulator_request(breq), .wlan_core_reset_n(wrst_n),
    .bluetooth_core_reset_n(brst_n));

  rcr_top #(.POR_CYCLES(PC)) uut (.clock(clock), .rst_n(rst_n), .core_supply_good(cs),
    .io_supply_good(ios), .wlan_regulator_request(wreq), .bluetooth_regulator_request(breq),
    .wlan_core_reset_n(wrst_n), .bluetooth_core_reset_n(brst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .regulator_enable(reg_en), .por_active(por),
    .wlan_core_hold(wh), .bluetooth_core_hold(bh), .fm_core_hold(fh));

  // expected status word and outputs, built from the levels the bench applied
  function automatic logic [37:0] stat();
    logic r, w, b, f;
    r = pins[0] | pins[1];
    w = !r | por_e | !pins[2] | ctrl[0];
    b = !r | por_e | !pins[3] | ctrl[1];
    f = b | ctrl[2];
    return {1'b0, 21'h0, ios, cs, pins, f, b, w, por_e, r, r, por_e, w, b, f};
  endfunction : stat

  task finish_test();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // one apb transfer; the note {err, data, outputs} is queued before the request goes out
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      input logic [32:0] e, input logic full);
    logic [37:0] s;
    s = stat();
    if (!w && a == ADDR_STATUS)
      e = {1'b0, s[36:5]};
    q_val.push_back({e, s[4:0]});
    q_msk.push_back({1'b1, {32{full}}, 5'h1f});
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // result watcher: every answered transfer takes the oldest note
  always @(posedge clock) begin
    if (pready === 1'b1) begin
      ev = q_val.pop_front();
      em = q_msk.pop_front();
      checked++;
      if ((({pslverr, prdata, reg_en, por, wh, bh, fh} ^ ev) & em) !== 38'h0) begin
        n_mismatch++;
        $display("mismatch t=%0t got %h exp %h", $time,
          {pslverr, prdata, reg_en, por, wh, bh, fh}, ev);
      end
    end
  end

  // watchdog: far beyond the expected run length
  initial begin
    repeat (PC * 4 + 4000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end

  initial begin
    {rst_n, cs, ios, psel, penable, pwrite, paddr, pwdata, pins, ctrl} = '0;
    por_e = 1'b1;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    cs <= 1'b1;
    ios <= 1'b1;
    // accesses wait out the whole power-up span
    repeat (PC + 6) @(posedge clock);
    por_e = 1'b0;
    xfer(1'b0, ADDR_STATUS, 32'h0, 33'h0, 1'b1);
    // every pin combination twice, each with a random soft-hold word
    for (int i = 0; i < 32; i++) begin
      @(posedge clock);
      pins <= i[3:0];
      d = $random(seed);
      repeat (8) @(posedge clock);
      xfer(1'b1, ADDR_CTRL, d, 33'h0, 1'b0);
      ctrl = d[2:0];
      repeat (4) @(posedge clock);
      xfer(1'b0, ADDR_STATUS, 32'h0, 33'h0, 1'b1);
      xfer(1'b0, ADDR_CTRL, 32'h0, {30'h0, ctrl}, 1'b1);
    end
    xfer(1'b1, ADDR_CTRL, 32'h0, 33'h0, 1'b0);
    ctrl = 3'h0;
    // losing either supply restarts the power-up reset, which ends within its span
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      {cs, ios} <= k ? 2'b10 : 2'b01;
      repeat (6) @(posedge clock);
      por_e = 1'b1;
      xfer(1'b0, ADDR_STATUS, 32'h0, 33'h0, 1'b1);
      {cs, ios} <= 2'b11;
      repeat (PC + 8) @(posedge clock);
      por_e = 1'b0;
      xfer(1'b0, ADDR_STATUS, 32'h0, 33'h0, 1'b1);
    end
    // refused accesses leave everything as it was
    xfer(1'b0, 12'h00c, 32'h0, {1'b1, 32'h0}, 1'b1);
    xfer(1'b1, ADDR_STATUS, $random(seed), {1'b1, 32'h0}, 1'b0);
    xfer(1'b1, 12'hffc, 32'h7, {1'b1, 32'h0}, 1'b0);
    xfer(1'b0, ADDR_POR_COUNT, 32'h0, {1'b0, 32'(PC - 1)}, 1'b1);
    xfer(1'b0, ADDR_CTRL, 32'h0, 33'h0, 1'b1);
    xfer(1'b0, ADDR_STATUS, 32'h0, 33'h0, 1'b1);
    finish_test();
  end
endmodule : tb_top
